/* File: hdl/sr_pkg.sv */
// package: register map, field layouts, modes and line roles for sync routing
package sr_pkg;

  localparam int NUM_LAYERS = 4;
  localparam int NUM_LINES  = 4;
  localparam int ADDR_W     = 8;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LAYER  = 8'h04;
  localparam logic [7:0] ADDR_CMD    = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // writable bits of CTRL and CMD; all others read as zero
  localparam logic [31:0] CTRL_WMASK = 32'h003F_FFFF;
  localparam logic [31:0] CMD_WMASK  = 32'h0000_01FF;

  // layer clock source encoding
  localparam logic [1:0] CLK_SRC_SOFTWARE = 2'h0;
  localparam logic [1:0] CLK_SRC_INTERNAL = 2'h1;
  localparam logic [1:0] CLK_SRC_EXTERNAL = 2'h2;
  localparam logic [1:0] CLK_SRC_SYNC     = 2'h3;

  // layer trigger source encoding
  localparam logic [1:0] TRIG_SRC_FIRMWARE   = 2'h0;
  localparam logic [1:0] TRIG_SRC_EXT_A      = 2'h1;
  localparam logic [1:0] TRIG_SRC_BUS_LINE   = 2'h2;
  localparam logic [1:0] TRIG_SRC_INTERLAYER = 2'h3;

  // what a master layer puts on the inter-layer trigger line
  localparam logic [1:0] MASTER_SRC_EXT_A = 2'h0;
  localparam logic [1:0] MASTER_SRC_OWN   = 2'h1;
  localparam logic [1:0] MASTER_SRC_COUNT = 2'h2;

  // standard roles of the internal sync lines
  localparam int LINE_BUS_TRIGGER        = 0;
  localparam int LINE_TIMEBASE           = 1;
  localparam int LINE_INTERLAYER_TRIGGER = 2;
  localparam int LINE_INTERLAYER_CLOCK   = 3;

  typedef enum logic [2:0] {
    TRIG_SINGLE, TRIG_START_STOP, TRIG_GATE_HIGH, TRIG_GATE_LOW, TRIG_DIRECT
  } trig_mode_type;

  typedef enum logic [2:0] {
    OUT_BUFFER, OUT_CLOCK, OUT_LAYER, OUT_ECHO, OUT_ALARM
  } out_mode_type;

  typedef enum logic {RUN_IDLE, RUN_ACTIVE} run_state_type;

  typedef struct packed {
    logic [9:0]    reserved;
    logic [1:0]    master_src;
    logic          trig_to_line0;
    logic [3:0]    out_line_en;
    logic [3:0]    in_line_en;
    logic [1:0]    layer_sel;
    logic [1:0]    echo_sel;
    out_mode_type  out_mode;
    logic          edge_fall;
    trig_mode_type trig_mode;
  } ctrl_type;

  typedef struct packed {
    logic       drive_clock;
    logic       drive_trigger;
    logic       single_line;
    logic       clk_line3;
    logic [1:0] clk_src;
    logic [1:0] trig_src;
  } layer_cfg_type;

  typedef struct packed {
    logic [22:0] reserved;
    logic        stop;
    logic [3:0]  sw_clock;
    logic [3:0]  sw_start;
  } cmd_type;

  typedef struct packed {
    logic [21:0] reserved;
    logic [3:0]  layer_trig;
    logic [3:0]  lines;
    logic        sync_in;
    logic        run;
  } status_type;

  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] LAYER_RESET = 32'h0000_0000;

endpackage

/* File: hdl/level_sync.sv */
// two-stage synchroniser for one level input
`timescale 1ns/1ps
module level_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      dout
);

  logic stage1_q;
  logic stage2_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else begin
      stage1_q <= din;
      stage2_q <= stage1_q;
    end
  end

  assign dout = stage2_q;

endmodule

/* File: hdl/sync_trigger_routing.sv */
// external sync trigger modes, sync output modes and internal line routing
//
// Summary of operation
// - single mode: selected edge of synced input starts the application
// - start/stop mode: selected edge starts, next same edge stops
// - gate high runs while input high; gate low runs while input low
// - direct mode: no chassis trigger, input goes to one layer pin
// - buffer output mode copies the external input to the output
// - clock export mode drives the chassis clock at half rate onto the output
// - layer output mode takes the output from one selected layer
// - output may echo any internal line or act as alarm
// - four two-way internal lines shared by processor and layers
// - ext input and output may go to any line; other sources have fixed lines
// - line 0 trigger, 1 timebase, 2 inter-layer trigger, 3 clock
// - external input or output can be mapped onto any line
// - layer trigger from firmware, ext line a, line 0 or line 2
// - layer clock internal, ext line b or a, line 1 or 3
// - layer may drive its trigger to line 2, clock to line 3
// - clock source code: 0 software, 1 internal, 2 external, 3 sync
// - processor samples external input and drives result on line 0
// - master layer drives line 2 from ext, own trigger or count
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module sync_trigger_routing (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        ext_sync_in,
  output logic             ext_sync_out,
  input  wire logic        alarm_in,
  input  wire logic [3:0]  sync_line_i,
  output logic [3:0]       sync_line_o,
  output logic [3:0]       sync_line_oe,
  input  wire logic [3:0]  layer_ext_line_a,
  input  wire logic [3:0]  layer_ext_line_b,
  input  wire logic [3:0]  layer_own_trigger,
  input  wire logic [3:0]  layer_own_clock,
  input  wire logic [3:0]  layer_terminal_count,
  input  wire logic [3:0]  layer_int_clock,
  input  wire logic [3:0]  layer_sync_out,
  output logic [3:0]       layer_trigger,
  output logic [3:0]       layer_clock,
  output logic [3:0]       layer_direct_in,
  output logic             app_run
);

  sr_pkg::ctrl_type                 ctrl_q,    ctrl_d;
  sr_pkg::layer_cfg_type [3:0]      layer_q,   layer_d;
  sr_pkg::cmd_type                  cmd_q,     cmd_d;
  sr_pkg::run_state_type            run_q,     run_d;
  sr_pkg::status_type               status;
  logic                             aw_have_q, aw_have_d;
  logic [7:0]                       aw_addr_q, aw_addr_d;
  logic                             w_have_q,  w_have_d;
  logic [31:0]                      w_data_q,  w_data_d;
  logic [3:0]                       w_strb_q,  w_strb_d;
  logic                             awready_q, awready_d;
  logic                             wready_q,  wready_d;
  logic                             bvalid_q,  bvalid_d;
  logic [1:0]                       bresp_q,   bresp_d;
  logic                             arready_q, arready_d;
  logic                             rvalid_q,  rvalid_d;
  logic [31:0]                      rdata_q,   rdata_d;
  logic [1:0]                       rresp_q,   rresp_d;
  logic [7:0]                       waddr;
  logic [7:0]                       raddr;
  logic                             sync_in_s;
  logic                             prev_q;
  logic                             edge_hit;
  logic                             app_run_q;
  logic                             ext_out_q, ext_out_d;
  logic                             any_l2, any_l3;
  logic                             l2_val, l3_val;
  logic [3:0]                       role_en,   role_val;
  logic [3:0]                       line_o_q,  line_o_d;
  logic [3:0]                       line_oe_q, line_oe_d;
  logic [3:0]                       ltrig_q,   ltrig_d;
  logic [3:0]                       lclk_q,    lclk_d;
  logic [3:0]                       ldir_q,    ldir_d;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic pick4(input logic [1:0] sel,
                                 input logic a, input logic b,
                                 input logic c, input logic d);
    logic res;
    res = a;
    case (sel)
      2'h1:    res = b;
      2'h2:    res = c;
      2'h3:    res = d;
      default: res = a;
    endcase
    return res;
  endfunction

  // external input reaches the clock domain only through two stages
  level_sync u_in_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (ext_sync_in),
    .dout    (sync_in_s)
  );

  // ---------------- register write channel
  assign waddr = {aw_addr_q[7:2], 2'h0};

  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    ctrl_d    = ctrl_q;
    layer_d   = layer_q;
    cmd_d     = sr_pkg::cmd_type'(32'h0000_0000);
    if (awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_have_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = sr_pkg::RESP_OKAY;
      case (waddr)
        sr_pkg::ADDR_CTRL: begin
          ctrl_d = sr_pkg::ctrl_type'(merge(ctrl_q, w_data_q, w_strb_q) & sr_pkg::CTRL_WMASK);
        end
        sr_pkg::ADDR_LAYER: begin
          layer_d = merge(layer_q, w_data_q, w_strb_q);
        end
        sr_pkg::ADDR_CMD: begin
          // one write starts every selected layer whose trig_src is firmware in the same cycle
          cmd_d = sr_pkg::cmd_type'(merge(32'h0000_0000, w_data_q, w_strb_q)
                                    & sr_pkg::CMD_WMASK);
        end
        sr_pkg::ADDR_STATUS: begin
          bresp_d = sr_pkg::RESP_OKAY;
        end
        default: begin
          bresp_d = sr_pkg::RESP_DECERR;
        end
      endcase
    end
    awready_d = !aw_have_d;
    wready_d  = !w_have_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= sr_pkg::RESP_OKAY;
      ctrl_q    <= sr_pkg::ctrl_type'(sr_pkg::CTRL_RESET);
      layer_q   <= sr_pkg::LAYER_RESET;
      cmd_q     <= sr_pkg::cmd_type'(32'h0000_0000);
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      ctrl_q    <= ctrl_d;
      layer_q   <= layer_d;
      cmd_q     <= cmd_d;
    end
  end

  // ---------------- register read channel
  assign raddr = {araddr[7:2], 2'h0};

  always_comb begin
    status            = sr_pkg::status_type'(32'h0000_0000);
    status.run        = app_run_q;
    status.sync_in    = sync_in_s;
    status.lines      = sync_line_i;
    status.layer_trig = ltrig_q;
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = sr_pkg::RESP_OKAY;
      case (raddr)
        sr_pkg::ADDR_CTRL:   rdata_d = ctrl_q;
        sr_pkg::ADDR_LAYER:  rdata_d = layer_q;
        sr_pkg::ADDR_CMD:    rdata_d = 32'h0000_0000;
        sr_pkg::ADDR_STATUS: rdata_d = status;
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = sr_pkg::RESP_DECERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= sr_pkg::RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // ---------------- application run state
  assign edge_hit = ctrl_q.edge_fall ? (prev_q & ~sync_in_s) : (~prev_q & sync_in_s);

  always_comb begin
    run_d = run_q;
    unique case (ctrl_q.trig_mode)
      sr_pkg::TRIG_SINGLE: begin
        if (cmd_q.stop) begin
          run_d = sr_pkg::RUN_IDLE;
        end else if (edge_hit) begin
          run_d = sr_pkg::RUN_ACTIVE;
        end
      end
      sr_pkg::TRIG_START_STOP: begin
        if (cmd_q.stop) begin
          run_d = sr_pkg::RUN_IDLE;
        end else if (edge_hit) begin
          run_d = (run_q == sr_pkg::RUN_ACTIVE) ? sr_pkg::RUN_IDLE : sr_pkg::RUN_ACTIVE;
        end
      end
      sr_pkg::TRIG_GATE_HIGH: run_d = sync_in_s ? sr_pkg::RUN_ACTIVE : sr_pkg::RUN_IDLE;
      sr_pkg::TRIG_GATE_LOW:  run_d = sync_in_s ? sr_pkg::RUN_IDLE : sr_pkg::RUN_ACTIVE;
      default:                run_d = sr_pkg::RUN_IDLE;
    endcase
  end

  // ---------------- external output and line drivers
  always_comb begin
    ext_out_d = 1'b0;
    unique case (ctrl_q.out_mode)
      sr_pkg::OUT_BUFFER: ext_out_d = sync_in_s;
      // toggling every cycle exports the chassis clock at half rate
      sr_pkg::OUT_CLOCK:  ext_out_d = ~ext_out_q;
      sr_pkg::OUT_LAYER:  ext_out_d = layer_sync_out[ctrl_q.layer_sel];
      sr_pkg::OUT_ECHO:   ext_out_d = sync_line_i[ctrl_q.echo_sel];
      sr_pkg::OUT_ALARM:  ext_out_d = alarm_in;
      default:            ext_out_d = 1'b0;
    endcase
  end

  // lowest numbered layer wins if several claim a line
  always_comb begin
    any_l2 = 1'b0;
    any_l3 = 1'b0;
    l2_val = 1'b0;
    l3_val = 1'b0;
    for (int i = sr_pkg::NUM_LAYERS - 1; i >= 0; i--) begin
      if (layer_q[i].drive_trigger) begin
        any_l2 = 1'b1;
        l2_val = pick4(ctrl_q.master_src, layer_ext_line_a[i], layer_own_trigger[i],
                       layer_terminal_count[i], 1'b0);
      end
      if (layer_q[i].drive_clock) begin
        any_l3 = 1'b1;
        l3_val = layer_own_clock[i];
      end
    end
  end

  // fixed line roles: trigger, timebase, inter-layer trigger and clock
  assign role_en  = {any_l3, any_l2, 1'b0, ctrl_q.trig_to_line0};
  assign role_val = {l3_val, l2_val, 1'b0, app_run_q};

  for (genvar n = 0; n < sr_pkg::NUM_LINES; n++) begin : g_line
    // every line gets identical routing; only enabled sources drive it
    assign line_oe_d[n] = ctrl_q.in_line_en[n] | ctrl_q.out_line_en[n] | role_en[n];
    assign line_o_d[n]  = ctrl_q.in_line_en[n]  ? sync_in_s :
                          ctrl_q.out_line_en[n] ? ext_out_q : role_val[n];
  end

  for (genvar g = 0; g < sr_pkg::NUM_LAYERS; g++) begin : g_layer
    assign ltrig_d[g] = pick4(layer_q[g].trig_src, cmd_q.sw_start[g], layer_ext_line_a[g],
                              sync_line_i[sr_pkg::LINE_BUS_TRIGGER],
                              sync_line_i[sr_pkg::LINE_INTERLAYER_TRIGGER]);
    assign lclk_d[g]  = pick4(layer_q[g].clk_src, cmd_q.sw_clock[g], layer_int_clock[g],
                              layer_q[g].single_line ? layer_ext_line_a[g]
                                                     : layer_ext_line_b[g],
                              layer_q[g].clk_line3 ? sync_line_i[sr_pkg::LINE_INTERLAYER_CLOCK]
                                                   : sync_line_i[sr_pkg::LINE_TIMEBASE]);
    assign ldir_d[g]  = (ctrl_q.trig_mode == sr_pkg::TRIG_DIRECT) &&
                        (ctrl_q.layer_sel == 2'(g)) && sync_in_s;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q     <= sr_pkg::RUN_IDLE;
      app_run_q <= 1'b0;
      prev_q    <= 1'b0;
      ext_out_q <= 1'b0;
      line_o_q  <= 4'h0;
      line_oe_q <= 4'h0;
      ltrig_q   <= 4'h0;
      lclk_q    <= 4'h0;
      ldir_q    <= 4'h0;
    end else begin
      run_q     <= run_d;
      app_run_q <= (run_d == sr_pkg::RUN_ACTIVE);
      prev_q    <= sync_in_s;
      ext_out_q <= ext_out_d;
      line_o_q  <= line_o_d;
      line_oe_q <= line_oe_d;
      ltrig_q   <= ltrig_d;
      lclk_q    <= lclk_d;
      ldir_q    <= ldir_d;
    end
  end

  assign awready         = awready_q;
  assign wready          = wready_q;
  assign bvalid          = bvalid_q;
  assign bresp           = bresp_q;
  assign arready         = arready_q;
  assign rvalid          = rvalid_q;
  assign rdata           = rdata_q;
  assign rresp           = rresp_q;
  assign ext_sync_out    = ext_out_q;
  assign sync_line_o     = line_o_q;
  assign sync_line_oe    = line_oe_q;
  assign layer_trigger   = ltrig_q;
  assign layer_clock     = lclk_q;
  assign layer_direct_in = ldir_q;
  assign app_run         = app_run_q;

  // ---------------- checks
  logic echo_bit;
  logic drive_req;

  assign echo_bit  = sync_line_i[ctrl_q.echo_sel];
  assign drive_req = |{ctrl_q.in_line_en, ctrl_q.out_line_en, role_en};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_single_start;
    (ctrl_q.trig_mode == sr_pkg::TRIG_SINGLE) && edge_hit && !cmd_q.stop |=> app_run;
  endproperty
  a_single_start: assert property (p_single_start) else $error("single edge did not start");

  property p_start_stop;
    (ctrl_q.trig_mode == sr_pkg::TRIG_START_STOP) && edge_hit && !cmd_q.stop
      |=> (app_run != $past(app_run));
  endproperty
  a_start_stop: assert property (p_start_stop) else $error("start/stop edge did not toggle");

  property p_gate_high;
    (ctrl_q.trig_mode == sr_pkg::TRIG_GATE_HIGH) |=> (app_run == $past(sync_in_s));
  endproperty
  a_gate_high: assert property (p_gate_high) else $error("gate high run wrong");

  property p_gate_low;
    (ctrl_q.trig_mode == sr_pkg::TRIG_GATE_LOW) |=> (app_run != $past(sync_in_s));
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("gate low run wrong");

  property p_direct_idle;
    (ctrl_q.trig_mode == sr_pkg::TRIG_DIRECT) |=> !app_run;
  endproperty
  a_direct_idle: assert property (p_direct_idle) else $error("direct mode ran application");

  property p_buffer;
    (ctrl_q.out_mode == sr_pkg::OUT_BUFFER) |=> (ext_sync_out == $past(sync_in_s));
  endproperty
  a_buffer: assert property (p_buffer) else $error("buffer output mismatch");

  property p_clock_export;
    (ctrl_q.out_mode == sr_pkg::OUT_CLOCK) [*2] |-> (ext_sync_out != $past(ext_sync_out));
  endproperty
  a_clock_export: assert property (p_clock_export) else $error("clock export not toggling");

  property p_echo;
    (ctrl_q.out_mode == sr_pkg::OUT_ECHO) |=> (ext_sync_out == $past(echo_bit));
  endproperty
  a_echo: assert property (p_echo) else $error("echo output mismatch");

  property p_release;
    !drive_req |=> (sync_line_oe == 4'h0);
  endproperty
  a_release: assert property (p_release) else $error("line driven without a source");

  property p_line0;
    ctrl_q.trig_to_line0 && !ctrl_q.in_line_en[0] && !ctrl_q.out_line_en[0]
      |=> sync_line_oe[0] && (sync_line_o[0] == $past(app_run));
  endproperty
  a_line0: assert property (p_line0) else $error("line 0 not carrying run state");

  property p_sync_delay;
    ##2 (sync_in_s == $past(ext_sync_in, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("input sync depth wrong");

  c_single: cover property ((ctrl_q.trig_mode == sr_pkg::TRIG_SINGLE) && edge_hit ##1 app_run);
  c_stop: cover property ((ctrl_q.trig_mode == sr_pkg::TRIG_START_STOP) && app_run
                          && edge_hit ##1 !app_run);
  c_clock: cover property ((ctrl_q.out_mode == sr_pkg::OUT_CLOCK) [*3]);
  c_master: cover property (any_l2 ##1 sync_line_oe[2]);

endmodule

/* File: dv/sync_far_end.sv */
// far side model: external trigger source and the pulled-up internal sync lines
`timescale 1ns/1ps
module sync_far_end (
  input  wire logic       src_level,
  input  wire logic [3:0] line_o,
  input  wire logic [3:0] line_oe,
  output logic            ext_pin,
  output logic [3:0]      line_wire
);
  assign ext_pin   = src_level;
  // a released line floats up to its pull-up level
  assign line_wire = (line_o & line_oe) | ~line_oe;
endmodule

/* File: dv/sync_trigger_routing_tb.sv */
// self-checking bench for the sync trigger routing block
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, a, e); end end
module sync_trigger_routing_tb;
  logic        aclk = 0;
  logic        aresetn, awvalid, wvalid, bready, arvalid, rready, ext_src, alarm_in;
  logic        ext_sync_in, ext_sync_out, app_run, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rr;
  logic [3:0]  wstrb, sync_line_i, sync_line_o, sync_line_oe, layer_ext_line_a;
  logic [3:0]  layer_ext_line_b, layer_own_trigger, layer_own_clock, layer_terminal_count;
  logic [3:0]  layer_int_clock, layer_sync_out, layer_trigger, layer_clock, layer_direct_in;
  int          errors, comparisons, cycles;

  sync_trigger_routing i_dut (.*);
  sync_far_end i_far (.src_level(ext_src), .line_o(sync_line_o), .line_oe(sync_line_oe),
                      .ext_pin(ext_sync_in), .line_wire(sync_line_i));

  always #10 aclk = ~aclk;

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1;
    w = 1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready) begin
        aw = 0;
        awvalid <= 0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 0;
    `CHK(bresp, er)
  endtask

  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 0;
  endtask

  task automatic set_ctrl(input logic [2:0] tm, input logic [2:0] om, input logic [31:0] x);
    axi_wr(sr_pkg::ADDR_CTRL, x | {25'h0, om, 1'b0, tm}, sr_pkg::RESP_OKAY);
  endtask

  task automatic stop_run;
    axi_wr(sr_pkg::ADDR_CMD, 32'h0000_0100, sr_pkg::RESP_OKAY);
  endtask

  // move the external input, let it settle, then judge the run flag
  task automatic ext_chk(input logic v, input logic run);
    ext_src <= v;
    wt(6);
    `CHK(app_run, run)
  endtask

  task automatic t_regs;
    axi_rd(sr_pkg::ADDR_CTRL);
    `CHK(rd, 32'h0000_0000)
    axi_wr(8'h10, 32'h0000_0001, sr_pkg::RESP_DECERR);
    axi_rd(8'h10);
    `CHK(rr, sr_pkg::RESP_DECERR)
    axi_wr(sr_pkg::ADDR_CTRL, 32'hFFFF_FFFF, sr_pkg::RESP_OKAY);
    axi_rd(sr_pkg::ADDR_CTRL);
    `CHK(rd, sr_pkg::CTRL_WMASK)
    set_ctrl(sr_pkg::TRIG_SINGLE, sr_pkg::OUT_BUFFER, 0);
    $display("test regs done");
  endtask

  task automatic t_modes;
    set_ctrl(sr_pkg::TRIG_GATE_HIGH, sr_pkg::OUT_BUFFER, 0);
    ext_chk(1, 1);
    `CHK(ext_sync_out, 1'b1)
    ext_chk(0, 0);
    `CHK(ext_sync_out, 1'b0)
    set_ctrl(sr_pkg::TRIG_GATE_LOW, sr_pkg::OUT_BUFFER, 0);
    ext_chk(0, 1);
    set_ctrl(sr_pkg::TRIG_SINGLE, sr_pkg::OUT_BUFFER, 0);
    stop_run();
    ext_chk(1, 1);
    ext_chk(0, 1);
    stop_run();
    set_ctrl(sr_pkg::TRIG_SINGLE, sr_pkg::OUT_BUFFER, 32'h0000_0008);
    ext_chk(1, 0);
    ext_chk(0, 1);
    stop_run();
    set_ctrl(sr_pkg::TRIG_START_STOP, sr_pkg::OUT_BUFFER, 0);
    ext_chk(1, 1);
    ext_chk(0, 1);
    ext_chk(1, 0);
    ext_src <= 0;
    $display("test trigger modes done");
  endtask

  task automatic t_out;
    logic b;
    set_ctrl(sr_pkg::TRIG_GATE_HIGH, sr_pkg::OUT_CLOCK, 0);
    wt(3);
    b = ext_sync_out;
    @(posedge aclk);
    `CHK(ext_sync_out, ~b)
    set_ctrl(sr_pkg::TRIG_GATE_HIGH, sr_pkg::OUT_ALARM, 0);
    alarm_in <= 1;
    wt(3);
    `CHK(ext_sync_out, 1'b1)
    alarm_in <= 0;
    set_ctrl(sr_pkg::TRIG_GATE_HIGH, sr_pkg::OUT_ECHO, 32'h0000_2100);
    ext_src <= 1;
    wt(6);
    `CHK(sync_line_oe, 4'b0100)
    `CHK(ext_sync_out, 1'b1)
    ext_src <= 0;
    wt(6);
    `CHK(ext_sync_out, 1'b0)
    set_ctrl(sr_pkg::TRIG_GATE_HIGH, sr_pkg::OUT_LAYER, 32'h0000_0600);
    layer_sync_out <= 4'b1000;
    wt(4);
    `CHK(ext_sync_out, 1'b1)
    $display("test output modes done");
  endtask

  task automatic t_route;
    set_ctrl(sr_pkg::TRIG_GATE_HIGH, sr_pkg::OUT_BUFFER, 32'h0018_0000);
    axi_wr(sr_pkg::ADDR_LAYER, 32'h4004_0102, sr_pkg::RESP_OKAY);
    layer_ext_line_a <= 4'b0010;
    layer_int_clock <= 4'b0100;
    layer_own_trigger <= 4'b1000;
    ext_src <= 1;
    wt(8);
    `CHK(sync_line_oe, 4'b0101)
    `CHK(sync_line_o & sync_line_oe, 4'b0101)
    `CHK(layer_trigger, 4'b0011)
    `CHK(layer_clock[2], 1'b1)
    ext_src <= 0;
    set_ctrl(sr_pkg::TRIG_DIRECT, sr_pkg::OUT_BUFFER, 32'h0000_0200);
    ext_src <= 1;
    wt(6);
    `CHK(layer_direct_in, 4'b0010)
    $display("test routing done");
  endtask

  // output mapped to line 0, layer 2 masters lines 2 and 3, firmware pulses, reset while lines 0, 2 and 3 are driven
  task automatic t_cmd;
    ext_src <= 0;
    set_ctrl(sr_pkg::TRIG_GATE_HIGH, sr_pkg::OUT_BUFFER, 32'h0020_8000);
    axi_wr(sr_pkg::ADDR_LAYER, 32'h00C0_1C08, sr_pkg::RESP_OKAY);
    layer_ext_line_b <= 4'b0001;
    layer_own_clock <= 4'b0100;
    layer_terminal_count <= 4'b0100;
    wt(6);
    `CHK(sync_line_oe, 4'b1101)
    `CHK(sync_line_i, 4'b1110)
    `CHK(layer_clock, 4'b0011)
    axi_rd(sr_pkg::ADDR_STATUS);
    `CHK(rd, 32'h0000_0038)
    axi_wr(sr_pkg::ADDR_CMD, 32'h0000_0049, sr_pkg::RESP_OKAY);
    @(posedge aclk);
    `CHK(layer_trigger, 4'b1001)
    `CHK(layer_clock, 4'b0111)
    @(posedge aclk);
    `CHK(layer_trigger, 4'b0000)
    aresetn <= 0;
    wt(2);
    aresetn <= 1;
    @(posedge aclk);
    `CHK({awready, wready, arready, app_run, sync_line_oe}, 8'h00)
    axi_rd(sr_pkg::ADDR_CTRL);
    `CHK(rd, sr_pkg::CTRL_RESET)
    $display("test commands and reset done");
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ext_src, alarm_in, awprot, arprot,
     awaddr, araddr, wdata, wstrb, layer_ext_line_a, layer_ext_line_b, layer_own_trigger,
     layer_own_clock, layer_terminal_count, layer_int_clock, layer_sync_out} = '0;
    wt(6);
    aresetn <= 1;
    wt(2);
    t_regs();
    t_modes();
    t_out();
    t_route();
    t_cmd();
    summarize();
  end
endmodule
